// ==== core/dcp_pkg.sv ====
// Purpose: Constants for the cell progress and pattern match block
// Assumes: Plain register port, 32-bit data, word offsets
// Notes: Offsets are byte addresses of aligned words
// Contract
// RULE1: Per channel 16-bit read-only progress counter, zero at reset, writes ignored.
// RULE2: Counter holds bytes moved since last trigger event, binary, up to 65,535.
// RULE3: Counter reads zero before any byte, then adds one per byte moved.
// RULE4: In pattern detect mode a detected pattern clears the counter to zero.
// RULE5: Progress register bits 31 to 16 always read zero.
// RULE6: Pattern byte is 8-bit read/write, reset zero, bits 31 to 8 read zero.
// RULE7: In pattern terminate mode transfer ends when data equals pattern byte.
// RULE8: One cell moves per trigger event; cell size zero means 65,536 bytes.
// RULE9: Counter returns to zero when a new trigger event starts a cell.
package dcp_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_PROGRESS = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PATTERN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CELL_SIZE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
	localparam int CNT_W = 16;
	localparam int PAT_W = 8;
	localparam int MODE_W = 2;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [PAT_W-1:0] PAT_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
	localparam logic [CNT_W:0] CELL_ZERO_BYTES = 17'h1_0000;
	typedef enum logic [MODE_W-1:0] {
		DCP_MODE_NORMAL,
		DCP_MODE_DETECT,
		DCP_MODE_TERMINATE
	} dcp_mode_t;
	typedef enum {
		DCP_IDLE,
		DCP_CELL
	} dcp_state_t;
endpackage

// ==== core/dcp_match.sv ====
`timescale 1ns/1ns
// Purpose: Byte comparator against the pattern value
// Assumes: Same clock as the caller, byte valid one cycle
// Notes: Purely combinational
module dcp_match
	import dcp_pkg::*;
(
	input wire logic [PAT_W-1:0] data_byte,
	input wire logic byte_valid,
	input wire logic [PAT_W-1:0] pattern_value,
	output logic hit
);
	always_comb
	begin
		hit = byte_valid && (data_byte == pattern_value);
	end
endmodule // dcp_match

// ==== core/dcp_top.sv ====
`timescale 1ns/1ns
// Purpose: Cell progress counter and pattern byte for one DMA channel
// Assumes: Transfer engine strobes are on sys_clk
// Notes: Counter saturates at its top value within a cell
module dcp_top
	import dcp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rdata,
	input wire logic trig_event,
	input wire logic byte_moved,
	input wire logic [PAT_W-1:0] byte_data,
	output logic cell_busy,
	output logic cell_done,
	output logic match_end
);
	logic [CNT_W-1:0] progress_byte_count_reg, progress_byte_count_next;
	logic [PAT_W-1:0] pattern_value_reg, pattern_value_next;
	logic [CNT_W-1:0] bytes_per_event_reg, bytes_per_event_next;
	logic [MODE_W-1:0] mode_reg, mode_next;
	logic [CNT_W:0] remain_reg, remain_next;
	dcp_state_t state_reg, state_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic end_reg, end_next;
	logic hit;
	logic mv;

	dcp_match u_match (
		.data_byte(byte_data),
		.byte_valid(mv),
		.pattern_value(pattern_value_reg),
		.hit(hit)
	);

	// Bytes only count while a cell is open
	assign mv = byte_moved && (state_reg == DCP_CELL);

	// Software registers
	always_comb
	begin
		pattern_value_next = pattern_value_reg;
		bytes_per_event_next = bytes_per_event_reg;
		mode_next = mode_reg;
		if (wr_en)
		begin
			case (addr)
				OFS_PATTERN: pattern_value_next = wdata[PAT_W-1:0]; // RULE6
				OFS_CELL_SIZE: bytes_per_event_next = wdata[CNT_W-1:0];
				OFS_MODE: mode_next = wdata[MODE_W-1:0];
				default: ; // Progress register is read-only RULE1
			endcase
		end
	end

	// Cell engine and progress counter
	always_comb
	begin
		state_next = state_reg;
		remain_next = remain_reg;
		progress_byte_count_next = progress_byte_count_reg;
		done_next = 1'b0;
		end_next = 1'b0;
		case (state_reg)
			DCP_IDLE:
			begin
				if (trig_event)
				begin
					state_next = DCP_CELL;
					progress_byte_count_next = CNT_RESET; // RULE9
					// Zero size means a full 65,536 byte cell
					remain_next = (bytes_per_event_reg == CNT_RESET) ? CELL_ZERO_BYTES
						: {1'b0, bytes_per_event_reg}; // RULE8
				end
			end
			DCP_CELL:
			begin
				if (mv)
				begin
					remain_next = remain_reg - {{CNT_W{1'b0}}, 1'b1};
					if (progress_byte_count_reg != CNT_MAX) // RULE2
						progress_byte_count_next = progress_byte_count_reg + CNT_ONE; // RULE3
					if (hit && mode_reg == DCP_MODE_DETECT)
						progress_byte_count_next = CNT_RESET; // RULE4
					if (hit && mode_reg == DCP_MODE_TERMINATE)
					begin
						// Match ends the transfer at once
						state_next = DCP_IDLE; // RULE7
						end_next = 1'b1; // RULE7
						done_next = 1'b1;
					end
					else if (remain_reg == {{CNT_W{1'b0}}, 1'b1})
					begin
						state_next = DCP_IDLE; // RULE8
						done_next = 1'b1;
					end
				end
			end
			default: state_next = DCP_IDLE;
		endcase
		busy_next = (state_next == DCP_CELL);
	end

	// Read mux; unused upper bits read zero
	always_comb
	begin
		rdata_next = READ_ZERO;
		if (rd_en)
		begin
			case (addr)
				OFS_PROGRESS: rdata_next = {16'h0000, progress_byte_count_reg}; // RULE5
				OFS_PATTERN: rdata_next = {24'h00_0000, pattern_value_reg}; // RULE6
				OFS_CELL_SIZE: rdata_next = {16'h0000, bytes_per_event_reg};
				OFS_MODE: rdata_next = {30'h0000_0000, mode_reg};
				OFS_STATUS: rdata_next = {31'h0000_0000, busy_reg};
				default: rdata_next = READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			progress_byte_count_reg <= CNT_RESET; // RULE1
			pattern_value_reg <= PAT_RESET; // RULE6
			bytes_per_event_reg <= CNT_RESET;
			mode_reg <= DCP_MODE_NORMAL;
			remain_reg <= CELL_ZERO_BYTES;
			state_reg <= DCP_IDLE;
			rdata_reg <= READ_ZERO;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			end_reg <= 1'b0;
		end
		else
		begin
			progress_byte_count_reg <= progress_byte_count_next;
			pattern_value_reg <= pattern_value_next;
			bytes_per_event_reg <= bytes_per_event_next;
			mode_reg <= mode_next;
			remain_reg <= remain_next;
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			end_reg <= end_next;
		end
	end

	assign rdata = rdata_reg;
	assign cell_busy = busy_reg;
	assign cell_done = done_reg;
	assign match_end = end_reg;

	// Checks
	write_ignored_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE1
		(wr_en && addr == OFS_PROGRESS && !mv && !trig_event) |=>
		$stable(progress_byte_count_reg))
		else $error("progress counter changed by write");
	count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE3
		(mv && !hit && progress_byte_count_reg != CNT_MAX) |=>
		progress_byte_count_reg == $past(progress_byte_count_reg) + CNT_ONE)
		else $error("progress counter did not step by one");
	count_sat_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
		(progress_byte_count_reg == CNT_MAX && !(state_reg == DCP_IDLE && trig_event)
		&& !(hit && mode_reg == DCP_MODE_DETECT)) |=> progress_byte_count_reg == CNT_MAX)
		else $error("progress counter wrapped");
	detect_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
		(hit && mode_reg == DCP_MODE_DETECT) |=> progress_byte_count_reg == CNT_RESET)
		else $error("pattern detect did not clear counter");
	read_upper_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE5
		(rd_en && addr == OFS_PROGRESS) |=> rdata[DATA_W-1:CNT_W] == 16'h0000 &&
		rdata[CNT_W-1:0] == $past(progress_byte_count_reg))
		else $error("progress read wrong");
	pattern_rw_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
		(wr_en && addr == OFS_PATTERN) ##1 (rd_en && addr == OFS_PATTERN) |=>
		rdata == {24'h00_0000, $past(wdata[PAT_W-1:0], 2)})
		else $error("pattern byte readback wrong");
	term_end_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
		(hit && mode_reg == DCP_MODE_TERMINATE) |=> match_end && !cell_busy ##1 !match_end)
		else $error("terminate on match failed");
	cell_start_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE9
		(state_reg == DCP_IDLE && trig_event) |=> progress_byte_count_reg == CNT_RESET
		&& cell_busy)
		else $error("new cell did not clear counter");
	cell_len_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
		(mv && remain_reg == {{CNT_W{1'b0}}, 1'b1}) |=> cell_done && !cell_busy)
		else $error("cell did not end on its last byte");
	// Counter may only move on a byte or on a new cell
	count_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE2
		(!mv && !(state_reg == DCP_IDLE && trig_event)) |=> $stable(progress_byte_count_reg))
		else $error("progress counter moved without a byte");
	trig_ignored_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
		(state_reg == DCP_CELL && trig_event && !mv) |=> $stable(remain_reg) && cell_busy)
		else $error("trigger restarted an open cell");
	zero_size_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
		(state_reg == DCP_IDLE && trig_event && bytes_per_event_reg == CNT_RESET) |=>
		remain_reg == CELL_ZERO_BYTES)
		else $error("zero cell size not loaded as full cell");
	done_pulse_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE8
		cell_done |=> !cell_done)
		else $error("cell done held too long");
	// Mode 3 decodes as normal, so it too must leave the pattern inert
	normal_hit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE7
		(hit && mode_reg != DCP_MODE_DETECT && mode_reg != DCP_MODE_TERMINATE
		&& progress_byte_count_reg != CNT_MAX) |=>
		progress_byte_count_reg == $past(progress_byte_count_reg) + CNT_ONE && !match_end)
		else $error("pattern acted outside its modes");
	detect_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE4
		(hit && mode_reg == DCP_MODE_DETECT && remain_reg != {{CNT_W{1'b0}}, 1'b1}) |=>
		cell_busy && !match_end)
		else $error("pattern detect ended the cell");
	pattern_upper_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE6
		(rd_en && addr == OFS_PATTERN) |=> rdata[DATA_W-1:PAT_W] == '0)
		else $error("pattern upper bits not zero");
endmodule // dcp_top

// ==== test/dcp_engine_model.sv ====
// Purpose: Transfer engine model for one channel
// Assumes: Strobes change just after sys_clk rises
// Notes: Idle data lines show the inverse byte
`timescale 1ns/1ns
module dcp_engine_model
(
	input wire logic sys_clk,
	output logic trig_event,
	output logic byte_moved,
	output logic [7:0] byte_data
);
	initial
	begin
		trig_event = 1'h0;
		byte_moved = 1'h0;
		byte_data = 8'h00;
	end
	task automatic fire();
		@(posedge sys_clk);
		trig_event <= 1'h1;
		@(posedge sys_clk);
		trig_event <= 1'h0;
	endtask
	// Bytes back to back, one cell per event
	task automatic send(input int n, input logic [7:0] d);
		repeat (n)
		begin
			@(posedge sys_clk);
			byte_moved <= 1'h1;
			byte_data <= d;
		end
		@(posedge sys_clk);
		byte_moved <= 1'h0;
		byte_data <= ~d;
	endtask
endmodule // dcp_engine_model

// ==== test/dcp_top_tb_top.sv ====
// Purpose: Self-checking bench for the progress counter block
// Assumes: Engine model drives the transfer strobes
// Notes: The size zero cell costs 65,536 cycles
`timescale 1ns/1ns
module dcp_top_tb_top
	import dcp_pkg::*;
();
	logic sys_clk = 1'h0;
	logic resetn = 1'h0;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic [DATA_W-1:0] rdata;
	logic trig_event, byte_moved, cell_busy, cell_done, match_end;
	logic [7:0] byte_data, pat;
	int fail_count = 0, checks = 0, seed = 32'h322593bf, ends = 0, dones = 0, n;
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (match_end === 1'h1) ends <= ends + 1;
	always @(posedge sys_clk) if (cell_done === 1'h1) dones <= dones + 1;
	dcp_engine_model ENG (.sys_clk, .trig_event, .byte_moved, .byte_data);
	dcp_top DUT (.sys_clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .trig_event,
		.byte_moved, .byte_data, .cell_busy, .cell_done, .match_end);
	// Counter saturates instead of wrapping
	function automatic logic [31:0] exp_cnt(input int k);
		return (k > 65535) ? 32'h0000_ffff : 32'(k);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr_en <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_en <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		rd_en <= 1'h1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'h0;
		#1 chk(rdata, e);
	endtask
	task automatic do_reset();
		resetn <= 1'h0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'h1;
	endtask
	task automatic complete_run();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end
	initial
	begin
		do_reset();
		pat = 8'($random(seed));
		n = 4 + ($random(seed) & 15);
		rd(OFS_PROGRESS, 32'h0);
		rd(OFS_PATTERN, 32'h0);
		wr(OFS_PROGRESS, 32'hffff_ffff);
		rd(OFS_PROGRESS, 32'h0);
		rd(8'h40, 32'h0);
		wr(OFS_PATTERN, {24'hff_ffff, pat});
		rd(OFS_PATTERN, {24'h0, pat});
		wr(OFS_CELL_SIZE, 32'(n));
		rd(OFS_CELL_SIZE, 32'(n));
		ENG.fire();
		// Flags update at the launching edge; look once they have settled
		#1 chk({30'h0, cell_busy, cell_done}, 32'h2);
		rd(OFS_STATUS, 32'h1);
		rd(OFS_PROGRESS, 32'h0);
		ENG.send(n - 1, pat);
		rd(OFS_PROGRESS, exp_cnt(n - 1));
		ENG.send(1, pat);
		#1 chk({30'h0, cell_busy, cell_done}, 32'h1);
		rd(OFS_PROGRESS, exp_cnt(n));
		ENG.fire();
		rd(OFS_PROGRESS, 32'h0);
		ENG.send(n, ~pat);
		wr(OFS_MODE, {30'h0, DCP_MODE_TERMINATE});
		rd(OFS_MODE, {30'h0, DCP_MODE_TERMINATE});
		ENG.fire();
		ENG.send(2, ~pat);
		ENG.send(1, pat);
		rd(OFS_PROGRESS, 32'h3);
		chk({31'h0, cell_busy}, 32'h0);
		chk(32'(ends), 32'h1);
		chk(32'(dones), 32'h3);
		wr(OFS_MODE, {30'h0, DCP_MODE_DETECT});
		ENG.fire();
		ENG.send(2, ~pat);
		ENG.send(1, pat);
		rd(OFS_PROGRESS, 32'h0);
		ENG.send(1, ~pat);
		rd(OFS_PROGRESS, 32'h1);
		do_reset();
		rd(OFS_PATTERN, 32'h0);
		wr(OFS_CELL_SIZE, 32'h0);
		ENG.fire();
		ENG.send(65536, pat);
		#1 chk({30'h0, cell_busy, cell_done}, 32'h1);
		rd(OFS_PROGRESS, exp_cnt(65536));
		complete_run();
	end
endmodule // dcp_top_tb_top
